// *** hw/afr_cfg_engine.sv ***
`timescale 1ns/10ps
module afr_cfg_engine
   import afr_pkg::*;
(
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          srst,
   // launch requests
   input  wire logic          exec_go,
   input  wire logic [3:0]    opcode,
   input  wire logic [1:0]    sel_fpga,
   input  wire logic [9:0]    block,
   input  wire logic          sram_wr_go,
   input  wire logic          sram_rd_go,
   input  wire logic [21:0]   sram_addr,
   input  wire logic [15:0]   sram_wdata,
   // rom controller
   output afr_rom_cmd_t       rom_cmd,
   output logic               rom_valid,
   input  wire logic          rom_done,
   // sram controller
   output afr_sram_cmd_t      sram_cmd,
   output logic               sram_valid,
   input  wire logic          sram_ack,
   input  wire logic [15:0]   sram_rdata,
   // status
   output logic [15:0]        rd_data,
   output logic               idle
);

   typedef enum logic [1:0] {ST_IDLE, ST_ROM, ST_SRAM} afr_eng_st_t;

   afr_eng_st_t   st_q;
   afr_eng_st_t   st_d;
   afr_rom_cmd_t  rom_q;
   afr_sram_cmd_t sram_q;
   logic [15:0]   rd_q;
   logic          rom_v_q;
   logic          sram_v_q;

   wire logic       opc_ok  = (opcode <= OPC_LAST);
   wire logic       rom_go  = exec_go && opc_ok;
   wire logic       mem_go  = sram_wr_go || sram_rd_go;
   wire logic [3:0] grp     = opcode / OPC_GROUP;
   wire logic [3:0] tgt     = opcode % OPC_GROUP;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
         begin
            if (rom_go)
               st_d = ST_ROM;
            else if (mem_go)
               st_d = ST_SRAM;
         end
         ST_ROM:
         begin
            if (rom_done)
               st_d = ST_IDLE;
         end
         ST_SRAM:
         begin
            if (sram_ack)
               st_d = ST_IDLE;
         end
         default:
            st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_q     <= ST_IDLE;
         rom_q    <= '0;
         sram_q   <= '0;
         rd_q     <= RST_REG;
         rom_v_q  <= 1'b0;
         sram_v_q <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         rom_v_q  <= (st_q == ST_IDLE) && rom_go;
         sram_v_q <= (st_q == ST_IDLE) && !rom_go && mem_go;
         if ((st_q == ST_IDLE) && rom_go)
         begin
            rom_q.kind     <= afr_rom_kind_t'(grp[1:0]);
            rom_q.op_fpga  <= tgt[1:0];
            rom_q.sel_fpga <= sel_fpga;
            rom_q.block    <= block;
         end
         if ((st_q == ST_IDLE) && !rom_go && mem_go)
         begin
            sram_q.write <= sram_wr_go;
            sram_q.addr  <= sram_addr;
            sram_q.data  <= sram_wdata;
         end
         if ((st_q == ST_SRAM) && sram_ack && !sram_q.write)
            rd_q <= sram_rdata;
      end
   end

   assign rom_cmd    = rom_q;
   assign rom_valid  = rom_v_q;
   assign sram_cmd   = sram_q;
   assign sram_valid = sram_v_q;
   assign rd_data    = rd_q;
   assign idle       = (st_q == ST_IDLE);

endmodule

// *** hw/afr_pkg.sv ***
package afr_pkg;

   localparam int AFR_AW     = 5;
   localparam int AFR_DW     = 16;
   localparam int AFR_SLOTS  = 5;
   localparam int AFR_SAW    = 22;

   // sub-addresses
   localparam logic [4:0] ADR_LANES   = 5'h00;
   localparam logic [4:0] ADR_CHANS   = 5'h01;
   localparam logic [4:0] ADR_PAYEN   = 5'h02;
   localparam logic [4:0] ADR_ALIGN   = 5'h03;
   localparam logic [4:0] ADR_TEMP    = 5'h04;
   localparam logic [4:0] ADR_SUPPLY  = 5'h05;
   localparam logic [4:0] ADR_OPCTL   = 5'h06;
   localparam logic [4:0] ADR_BLOCK   = 5'h07;
   localparam logic [4:0] ADR_SWDATA  = 5'h08;
   localparam logic [4:0] ADR_ADDRLO  = 5'h09;
   localparam logic [4:0] ADR_ADDRHI  = 5'h0A;
   localparam logic [4:0] ADR_SRDATA  = 5'h0B;
   localparam logic [4:0] ADR_IDLE    = 5'h11;

   // writable bit masks and register reset value
   localparam logic [15:0] MASK_PAYEN  = 16'h5540;
   localparam logic [15:0] MASK_ALIGN  = 16'h000A;
   localparam logic [15:0] MASK_OPCTL  = 16'h07F8;
   localparam logic [15:0] MASK_BLOCK  = 16'h03FF;
   localparam logic [15:0] MASK_FULL   = 16'hFFFF;
   localparam logic [15:0] MASK_ADDRHI = 16'hC03F;
   localparam logic [15:0] RST_REG     = 16'h0000;

   // field positions
   localparam int PAYEN_LSB  = 6;
   localparam int CHUP_LSB   = 12;
   localparam int ALLUP_BIT  = 1;
   localparam int LASTUP_BIT = 0;
   localparam int ALIGN_BIT  = 3;
   localparam int INIT_BIT   = 1;
   localparam int TGT_LSB    = 9;
   localparam int TGT_MSB    = 10;
   localparam int EXEC_BIT   = 8;
   localparam int SRSEL_BIT  = 7;
   localparam int OPC_LSB    = 3;
   localparam int OPC_MSB    = 6;
   localparam int BLK_MSB    = 9;
   localparam int SWR_BIT    = 15;
   localparam int SRD_BIT    = 14;
   localparam int AHI_MSB    = 5;
   localparam int IDLE_BIT   = 15;

   localparam logic [3:0] OPC_LAST   = 4'hB;
   localparam logic [3:0] OPC_GROUP  = 4'h3;

   typedef enum logic [1:0] {
      AFR_PROGRAM,
      AFR_READBACK,
      AFR_IDENT,
      AFR_ERASE
   } afr_rom_kind_t;

   typedef struct packed {
      afr_rom_kind_t kind;
      logic [1:0]    op_fpga;
      logic [1:0]    sel_fpga;
      logic [9:0]    block;
   } afr_rom_cmd_t;

   typedef struct packed {
      logic          write;
      logic [21:0]   addr;
      logic [15:0]   data;
   } afr_sram_cmd_t;

endpackage

// *** hw/afr_regfile.sv ***
`timescale 1ns/10ps
module afr_regfile
   import afr_pkg::*;
#(
   parameter logic [14:0] FW_VERSION = 15'h0001  // arbitrary value
)
(
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   // register access from the serial bus decoder
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [AFR_AW-1:0]    reg_addr,
   input  wire logic [AFR_DW-1:0]    reg_wdata,
   output logic [AFR_DW-1:0]         reg_rdata,
   // transceiver status, asynchronous
   input  wire logic [2*AFR_SLOTS-1:0] lane_up,
   input  wire logic [AFR_SLOTS-1:0] chan_up,
   // monitor words
   input  wire logic [AFR_DW-1:0]    die_temp,
   input  wire logic [AFR_DW-1:0]    supply_mon,
   // control outputs
   output logic [AFR_SLOTS-1:0]      payload_en,
   output logic                      align_en,
   output logic                      xcvr_init,
   output logic                      sram_wr_sel,
   // rom controller
   output afr_rom_cmd_t              rom_cmd,
   output logic                      rom_valid,
   input  wire logic                 rom_done,
   // sram controller
   output afr_sram_cmd_t             sram_cmd,
   output logic                      sram_valid,
   input  wire logic                 sram_ack,
   input  wire logic [AFR_DW-1:0]    sram_rdata
);

   // configuration registers and read data
   logic [15:0] payen_q;
   logic [15:0] align_q;
   logic [15:0] opctl_q;
   logic [15:0] block_q;
   logic [15:0] swdata_q;
   logic [15:0] addrlo_q;
   logic [15:0] addrhi_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // edge history
   logic        exec_prev_q;
   logic        swr_prev_q;
   logic        srd_prev_q;

   // synchronisers
   logic [2*AFR_SLOTS-1:0] lane_s1_q;
   logic [2*AFR_SLOTS-1:0] lane_s2_q;
   logic [AFR_SLOTS-1:0]   chan_s1_q;
   logic [AFR_SLOTS-1:0]   chan_s2_q;

   // engine results
   logic [15:0] eng_rd;
   logic        eng_idle;

   // write decode
   wire logic wr_payen  = reg_wr && (reg_addr == ADR_PAYEN);
   wire logic wr_align  = reg_wr && (reg_addr == ADR_ALIGN);
   wire logic wr_opctl  = reg_wr && (reg_addr == ADR_OPCTL);
   wire logic wr_block  = reg_wr && (reg_addr == ADR_BLOCK);
   wire logic wr_swdata = reg_wr && (reg_addr == ADR_SWDATA);
   wire logic wr_addrlo = reg_wr && (reg_addr == ADR_ADDRLO);
   wire logic wr_addrhi = reg_wr && (reg_addr == ADR_ADDRHI);

   // status words
   logic [15:0] stat_lanes;
   logic [15:0] stat_chans;
   logic [15:0] stat_idle;

   always_comb
   begin
      stat_lanes = '0;
      stat_lanes[2*AFR_SLOTS-1:0] = lane_s2_q;
      stat_lanes[CHUP_LSB +: AFR_SLOTS-1] = chan_s2_q[AFR_SLOTS-2:0];
      stat_chans = '0;
      stat_chans[ALLUP_BIT]  = &chan_s2_q;
      stat_chans[LASTUP_BIT] = chan_s2_q[AFR_SLOTS-1];
      stat_idle  = {eng_idle, FW_VERSION};
   end

   // slot enables, one per payload
   genvar gi;
   generate
      for (gi = 0; gi < AFR_SLOTS; gi++)
      begin : g_payen
         assign payload_en[gi] = payen_q[PAYEN_LSB + 2*gi];
      end
   endgenerate

   // read mux, unmapped and undefined read as zero
   always_comb
   begin
      case (reg_addr)
         ADR_LANES:  rdata_d = stat_lanes;
         ADR_CHANS:  rdata_d = stat_chans;
         ADR_PAYEN:  rdata_d = payen_q;
         ADR_ALIGN:  rdata_d = align_q;
         ADR_TEMP:   rdata_d = die_temp;
         ADR_SUPPLY: rdata_d = supply_mon;
         ADR_OPCTL:  rdata_d = opctl_q;
         ADR_BLOCK:  rdata_d = block_q;
         ADR_SWDATA: rdata_d = swdata_q;
         ADR_ADDRLO: rdata_d = addrlo_q;
         ADR_ADDRHI: rdata_d = addrhi_q;
         ADR_SRDATA: rdata_d = eng_rd;
         ADR_IDLE:   rdata_d = stat_idle;
         default:    rdata_d = RST_REG;
      endcase
   end

   // register writes, undefined bits masked off
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         payen_q  <= RST_REG;
         align_q  <= RST_REG;
         opctl_q  <= RST_REG;
         block_q  <= RST_REG;
         swdata_q <= RST_REG;
         addrlo_q <= RST_REG;
         addrhi_q <= RST_REG;
      end
      else
      begin
         if (wr_payen)
            payen_q <= reg_wdata & MASK_PAYEN;
         if (wr_align)
            align_q <= reg_wdata & MASK_ALIGN;
         if (wr_opctl)
            opctl_q <= reg_wdata & MASK_OPCTL;
         if (wr_block)
            block_q <= reg_wdata & MASK_BLOCK;
         if (wr_swdata)
            swdata_q <= reg_wdata & MASK_FULL;
         if (wr_addrlo)
            addrlo_q <= reg_wdata & MASK_FULL;
         if (wr_addrhi)
            addrhi_q <= reg_wdata & MASK_ADDRHI;
      end
   end

   // read data and edge history
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdata_q     <= RST_REG;
         exec_prev_q <= 1'b0;
         swr_prev_q  <= 1'b0;
         srd_prev_q  <= 1'b0;
      end
      else
      begin
         if (reg_rd)
            rdata_q <= rdata_d;
         exec_prev_q <= opctl_q[EXEC_BIT];
         swr_prev_q  <= addrhi_q[SWR_BIT];
         srd_prev_q  <= addrhi_q[SRD_BIT];
      end
   end

   // two-flop synchronisers for transceiver status
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         lane_s1_q <= '0;
         lane_s2_q <= '0;
         chan_s1_q <= '0;
         chan_s2_q <= '0;
      end
      else
      begin
         lane_s1_q <= lane_up;
         lane_s2_q <= lane_s1_q;
         chan_s1_q <= chan_up;
         chan_s2_q <= chan_s1_q;
      end
   end

   // rising edge launches
   wire logic exec_go    = opctl_q[EXEC_BIT] && !exec_prev_q;
   wire logic sram_wr_go = addrhi_q[SWR_BIT] && !swr_prev_q;
   wire logic sram_rd_go = addrhi_q[SRD_BIT] && !srd_prev_q;

   wire logic [21:0] sram_addr = {addrhi_q[AHI_MSB:0], addrlo_q};

   afr_cfg_engine u_engine (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .exec_go    (exec_go),
      .opcode     (opctl_q[OPC_MSB:OPC_LSB]),
      .sel_fpga   (opctl_q[TGT_MSB:TGT_LSB]),
      .block      (block_q[BLK_MSB:0]),
      .sram_wr_go (sram_wr_go),
      .sram_rd_go (sram_rd_go),
      .sram_addr  (sram_addr),
      .sram_wdata (swdata_q),
      .rom_cmd    (rom_cmd),
      .rom_valid  (rom_valid),
      .rom_done   (rom_done),
      .sram_cmd   (sram_cmd),
      .sram_valid (sram_valid),
      .sram_ack   (sram_ack),
      .sram_rdata (sram_rdata),
      .rd_data    (eng_rd),
      .idle       (eng_idle)
   );

   // control outputs and read data
   assign align_en    = align_q[ALIGN_BIT];
   assign xcvr_init   = align_q[INIT_BIT];
   assign sram_wr_sel = opctl_q[SRSEL_BIT];
   assign reg_rdata   = rdata_q;

endmodule

// *** verif/afr_ctl_model.sv ***
`timescale 1ns/10ps
module afr_ctl_model
   import afr_pkg::*;
(
   // clock and pacing
   input  wire logic          sys_clk,
   input  wire logic [3:0]    lat,
   // commands
   input  wire logic          rom_valid,
   input  wire logic          sram_valid,
   input  wire afr_sram_cmd_t sram_cmd,
   // answers
   output logic               rom_done = 1'b0,
   output logic               sram_ack = 1'b0,
   output logic [15:0]        sram_rdata = 16'h0000
);
   logic [15:0] mem [logic [21:0]];
   int          rcnt = 0;
   int          scnt = 0;
   // answers after lat plus one cycles
   always @(posedge sys_clk)
   begin
      rcnt = rom_valid ? lat + 2 : (rcnt > 0 ? rcnt - 1 : 0);
      scnt = sram_valid ? lat + 2 : (scnt > 0 ? scnt - 1 : 0);
      rom_done <= (rcnt == 1);
      sram_ack <= (scnt == 1);
      if (sram_valid && sram_cmd.write)
         mem[sram_cmd.addr] = sram_cmd.data;
      // data bus toggles except when answering a read
      if (scnt == 1 && !sram_cmd.write)
         sram_rdata <= mem.exists(sram_cmd.addr) ? mem[sram_cmd.addr] : 16'h0000;
      else
         sram_rdata <= ~sram_rdata;
   end
endmodule

// *** verif/afr_regfile_props.sv ***
`timescale 1ns/10ps
module afr_regfile_props
   import afr_pkg::*;
#(
   parameter logic [14:0] FW_VERSION = 15'h0001
)
(
   // clock and reset
   input wire logic          sys_clk,
   input wire logic          srst,
   // register access
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [4:0]    reg_addr,
   input wire logic [15:0]   reg_wdata,
   input wire logic [15:0]   reg_rdata,
   // controls
   input wire logic [4:0]    payload_en,
   input wire logic          align_en,
   input wire logic          xcvr_init,
   // engine
   input wire afr_rom_cmd_t  rom_cmd,
   input wire logic          rom_valid,
   input wire logic          rom_done,
   input wire afr_sram_cmd_t sram_cmd,
   input wire logic          sram_valid,
   input wire logic          sram_ack
);
   logic busy_q;
   logic busy;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // engine busy from launch until the cycle after completion
   assign busy = busy_q | rom_valid | sram_valid;
   always_ff @(posedge sys_clk)
      busy_q <= ~srst & busy & ~(rom_done | sram_ack);
   sequence s_bad_op;
      reg_wr && reg_addr == ADR_OPCTL && reg_wdata[8] && reg_wdata[6:3] > OPC_LAST;
   endsequence
   sequence s_hi_wr;
      $past(reg_wr, 2) && $past(reg_addr, 2) == ADR_ADDRHI;
   endsequence
   a_unmapped_zero:
      assert property (reg_rd && reg_addr > ADR_SRDATA && reg_addr != ADR_IDLE |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_idle_version:
      assert property (reg_rd && reg_addr == ADR_IDLE |=> reg_rdata == {~$past(busy), FW_VERSION})
      else $error("idle word wrong");
   a_payload_en:
      assert property (reg_wr && reg_addr == ADR_PAYEN |=> payload_en ==
         {$past(reg_wdata[14]), $past(reg_wdata[12]), $past(reg_wdata[10]), $past(reg_wdata[8]), $past(reg_wdata[6])})
      else $error("payload enables wrong");
   a_align_init:
      assert property (reg_wr && reg_addr == ADR_ALIGN |=> {align_en, xcvr_init} == {$past(reg_wdata[3]), $past(reg_wdata[1])})
      else $error("align or init wrong");
   a_bad_opcode:
      assert property (s_bad_op |-> ##2 !rom_valid)
      else $error("reserved opcode launched");
   a_rom_single:
      assert property (rom_valid |=> !rom_valid [*3])
      else $error("rom launch repeated");
   a_rom_source:
      assert property (rom_valid |-> $past(reg_wr, 2) && $past(reg_addr, 2) == ADR_OPCTL
         && rom_cmd.sel_fpga == $past(reg_wdata[10:9], 2))
      else $error("rom launch without execute write");
   a_rom_kind:
      assert property (rom_valid |-> rom_cmd.kind == afr_rom_kind_t'(2'($past(reg_wdata[6:3], 2) / 4'h3))
         && rom_cmd.op_fpga == 2'($past(reg_wdata[6:3], 2) % 4'h3))
      else $error("opcode decode wrong");
   a_sram_source:
      assert property (sram_valid |-> s_hi_wr ##0 (sram_cmd.addr[21:16] == $past(reg_wdata[5:0], 2)
         && sram_cmd.write == $past(reg_wdata[15], 2)))
      else $error("sram access wrong");
endmodule

// *** verif/afr_regfile_tb.sv ***
`timescale 1ns/10ps
module afr_regfile_tb;
   import afr_pkg::*;
   localparam logic [14:0] FW = 15'h2A5C;  // arbitrary value
   logic          sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   logic          align_en, xcvr_init, sram_wr_sel, rom_valid, rom_done, sram_valid, sram_ack;
   logic [4:0]    reg_addr = 5'h00, chan_up = 5'h00, payload_en;
   logic [9:0]    lane_up = 10'h000, blk;
   logic [15:0]   reg_wdata = 16'h0000, die_temp = 16'h0000, supply_mon = 16'h0000;
   logic [15:0]   reg_rdata, sram_rdata, rdv, d, st3 = 16'h0000;
   logic [15:0]   sh [32] = '{default: 16'h0000};
   logic [15:0]   q [$];
   logic [21:0]   sa;
   logic [3:0]    lat = 4'h0;
   logic [1:0]    t;
   afr_rom_cmd_t  rom_cmd, re;
   afr_rom_cmd_t  rq [$];
   afr_sram_cmd_t sram_cmd, se;
   afr_sram_cmd_t sq [$];
   int            seed = 32'h2295E5DF, bad_count = 0, check_count = 0;
   afr_regfile #(.FW_VERSION(FW)) i_dut (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .lane_up, .chan_up, .die_temp, .supply_mon, .payload_en, .align_en, .xcvr_init, .sram_wr_sel, .rom_cmd,
      .rom_valid, .rom_done, .sram_cmd, .sram_valid, .sram_ack, .sram_rdata);
   afr_ctl_model i_ctl (.sys_clk, .lat, .rom_valid, .sram_valid, .sram_cmd, .rom_done, .sram_ack, .sram_rdata);
   initial
      forever #25 sys_clk = ~sys_clk;
   task automatic cmp(logic [38:0] g, logic [38:0] e, logic [38:0] m);
      check_count++;
      if ((g & m) !== (e & m))
      begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [15:0] mk(logic [4:0] a);
      case (a)
         ADR_PAYEN: mk = MASK_PAYEN;
         ADR_ALIGN: mk = MASK_ALIGN;
         ADR_OPCTL: mk = MASK_OPCTL;
         ADR_BLOCK: mk = MASK_BLOCK;
         ADR_SWDATA, ADR_ADDRLO: mk = MASK_FULL;
         ADR_ADDRHI: mk = MASK_ADDRHI;
         default: mk = 16'h0000;
      endcase
   endfunction
   function automatic logic [15:0] ex(logic [4:0] a);
      case (a)
         ADR_LANES: ex = {chan_up[3:0], 2'b00, lane_up};
         ADR_CHANS: ex = {14'h0000, &chan_up, chan_up[4]};
         ADR_TEMP: ex = die_temp;
         ADR_SUPPLY: ex = supply_mon;
         ADR_SRDATA: ex = st3;
         ADR_IDLE: ex = {1'b1, FW};
         default: ex = sh[a];
      endcase
   endfunction
   task automatic wr(logic [4:0] a, logic [15:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      sh[a] = v & mk(a);
      @(negedge sys_clk);
      reg_wr = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic rd(logic [4:0] a, logic c);
      if (c)
         q.push_back(ex(a));
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      rdv = reg_rdata;
      @(negedge sys_clk);
   endtask
   // host waits for the idle flag, bounded
   task automatic poll;
      int n;
      n = 0;
      rd(ADR_IDLE, 1'b0);
      while (rdv[15] !== 1'b1)
      begin
         n++;
         if (n > 40)
         begin
            cmp(39'h0, 39'h1, 39'h1);
            summarize;
         end
         rd(ADR_IDLE, 1'b0);
      end
   endtask
   // results are matched against the oldest note
   always @(posedge sys_clk)
      rd_seen <= reg_rd;
   always @(negedge sys_clk)
   begin
      if (rd_seen && q.size() > 0)
         cmp(reg_rdata, q.pop_front(), {39{1'b1}});
      if (rom_valid)
      begin
         re = (rq.size() > 0) ? rq.pop_front() : ~rom_cmd;
         cmp(rom_cmd, re, {39{1'b1}});
      end
      if (sram_valid)
      begin
         se = (sq.size() > 0) ? sq.pop_front() : ~sram_cmd;
         cmp(sram_cmd, se, se.write ? {39{1'b1}} : {23'h7FFFFF, 16'h0000});
      end
   end
   initial
   begin
      repeat (8) @(negedge sys_clk);
      srst = 1'b0;
      for (int a = 0; a < 32; a++)
         rd(5'(a), 1'b1);
      $display("reset pass done");
      repeat (3)
      begin
         lane_up = 10'($random(seed));
         chan_up = 5'($random(seed));
         die_temp = 16'($random(seed));
         supply_mon = 16'($random(seed));
         for (int a = 0; a < 32; a++)
         begin
            d = 16'($random(seed));
            d[8] = d[8] & (a != 6);
            d[15:14] = d[15:14] & {2{a != 10}};
            wr(5'(a), d);
         end
         for (int a = 0; a < 32; a++)
            rd(5'(a), 1'b1);
         cmp({payload_en, align_en, xcvr_init, sram_wr_sel}, {sh[2][14], sh[2][12], sh[2][10], sh[2][8],
            sh[2][6], sh[3][3], sh[3][1], sh[6][7]}, {39{1'b1}});
         $display("register pass done");
      end
      for (int op = 0; op < 16; op++)
      begin
         t = 2'(op % 3 + 1);
         blk = 10'($random(seed));
         lat = 4'($random(seed));
         wr(ADR_BLOCK, {6'h00, blk});
         poll;
         if (op <= 11)
            rq.push_back('{afr_rom_kind_t'(op / 3), 2'(op % 3), t, blk});
         wr(ADR_OPCTL, {5'h00, t, 1'b1, 1'b0, 4'(op), 3'h0});
         if (op > 11)
            rd(ADR_IDLE, 1'b1);
         repeat (3) @(negedge sys_clk);
         poll;
         wr(ADR_OPCTL, {5'h00, t, 1'b1, 1'b0, 4'(op), 3'h0});
         repeat (3) @(negedge sys_clk);
         poll;
         wr(ADR_OPCTL, {5'h00, t, 1'b0, 1'b0, 4'(op), 3'h0});
      end
      cmp(rq.size(), 0, {39{1'b1}});
      $display("opcode pass done");
      repeat (6)
      begin
         sa = 22'($random(seed));
         d = 16'($random(seed));
         lat = 4'($random(seed));
         wr(ADR_SWDATA, d);
         wr(ADR_ADDRLO, sa[15:0]);
         sq.push_back('{1'b1, sa, d});
         wr(ADR_ADDRHI, {1'b1, 9'h000, sa[21:16]});
         repeat (3) @(negedge sys_clk);
         poll;
         wr(ADR_ADDRHI, {10'h000, sa[21:16]});
         sq.push_back('{1'b0, sa, 16'h0000});
         wr(ADR_ADDRHI, {2'b01, 8'h00, sa[21:16]});
         repeat (3) @(negedge sys_clk);
         poll;
         wr(ADR_ADDRHI, {10'h000, sa[21:16]});
         st3 = d;
         rd(ADR_SRDATA, 1'b1);
      end
      cmp(sq.size(), 0, {39{1'b1}});
      $display("staging pass done");
      summarize;
   end
endmodule
bind afr_regfile afr_regfile_props #(.FW_VERSION(FW_VERSION)) i_props (.sys_clk, .srst, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .payload_en, .align_en, .xcvr_init, .rom_cmd, .rom_valid, .rom_done,
   .sram_cmd, .sram_valid, .sram_ack);
